// >>> inc/clk_startup_pkg.sv
/*
 Package for the clock source and start-up sequencer: source codes,
 start-up field codes, delay counts and the selection carrier.
 Assumes a 125 MHz block clock and separate oscillator clock ticks.
*/
package clk_startup_pkg;

    // ------------------------------------------------------------
    // Source selection codes
    // ------------------------------------------------------------
    localparam logic [3:0] SRC_RC_8M = 4'h2;
    localparam logic [3:0] SRC_WDOG_128K = 4'h3;
    localparam logic [2:0] XTAL_MODE_MIN = 3'h4;
    localparam logic [3:0] SRC_FACTORY_DEFAULT = 4'h2;
    localparam logic [1:0] SUT_FACTORY_DEFAULT = 2'h2;

    // ------------------------------------------------------------
    // Start-up field codes
    // ------------------------------------------------------------
    localparam logic [1:0] SUT_00 = 2'h0;
    localparam logic [1:0] SUT_01 = 2'h1;
    localparam logic [1:0] SUT_10 = 2'h2;
    localparam logic [1:0] SUT_11 = 2'h3;

    // ------------------------------------------------------------
    // Oscillator clock counts
    // ------------------------------------------------------------
    localparam logic [14:0] CK_6 = 15'h0006;
    localparam logic [14:0] CK_258 = 15'h0102;
    localparam logic [14:0] CK_1K = 15'h0400;
    localparam logic [14:0] CK_16K = 15'h4000;
    localparam logic [14:0] CK_RST_14 = 15'h000E;

    // Reset time-out in watchdog cycles
    localparam logic [13:0] WD_NONE = 14'h0000;
    localparam logic [13:0] WD_4MS1 = 14'h0200;
    localparam logic [13:0] WD_65MS = 14'h2000;

    // Amplifier modes for the crystal oscillator
    typedef enum logic [1:0] {
        AMP_0P4_0P9 = 2'h0,
        AMP_0P9_3P0 = 2'h1,
        AMP_3P0_8P0 = 2'h2,
        AMP_8P0_16P0 = 2'h3
    } amp_mode_t;

    // Clock selection register contents
    typedef struct packed {
        logic [3:0] src_select_field;
        logic [1:0] startup_field;
    } clk_sel_t;

    // Decoded start-up plan
    typedef struct packed {
        logic [14:0] osc_clocks;
        logic [13:0] wd_cycles;
        logic legal;
    } startup_plan_t;

endpackage

// >>> src/clock_source_startup_select.sv
/*
 Clock source selection and start-up sequencer. Holds the trim and
 clock selection registers, decodes the start-up table and times the
 start-up on oscillator and watchdog clock ticks, then releases the
 system clock. Assumes the tick inputs come from other oscillators and
 are synchronised here; fuses are stable while arst_n is low.
*/
// How it works
// - Each reset loads the factory trim value into the trim register.
// - Software may write the trim register and the RC trim output follows it.
// - Reset time-outs are always counted on watchdog ticks, whatever source runs.
// - Code 0010 picks the 8 MHz RC oscillator and is the factory default.
// - RC start-up gives 6 clocks from power-down and 6+14, 6+14+4.1ms or 6+14+65ms from reset; 11 is reserved.
// - The 128 kHz source uses the same table as the RC source; 11 is reserved.
// - The setting without reset time-out is refused while the reset pin is disabled.
// - For the crystal, selection bits 2 and 1 set the amplifier range.
// - Crystal with bit 0 clear: 258+4.1ms, 258+65ms, 1K+0, 1K+4.1ms, each plus 14 clocks.
// - Crystal with bit 0 set: 1K+65ms, 16K+0, 16K+4.1ms, 16K+65ms, each plus 14 clocks.
// - Crystal timing is chosen by selection bit 0 and both start-up bits.
// - Reset copies the fuses into the clock selection register, which then governs.
// - 4.1ms is 512 watchdog cycles and 65ms is 8192.
`timescale 1ns/1ps
module clock_source_startup_select
    import clk_startup_pkg::*;
#(
    parameter int TRIM_W = 8,
    parameter logic [13:0] WD_4MS1_CYC = WD_4MS1,
    parameter logic [13:0] WD_65MS_CYC = WD_65MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Fuses
    input wire logic [3:0] src_select_fuses,
    input wire logic [1:0] startup_fuses,
    input wire logic reset_pin_disable_fuse,
    input wire logic [TRIM_W-1:0] factory_trim,
    // Software writes
    input wire logic trim_wr,
    input wire logic [TRIM_W-1:0] trim_wdata,
    input wire logic sel_wr,
    input wire clk_sel_t sel_wdata,
    // Wake request and oscillator ticks from other domains
    input wire logic wake_req,
    input wire logic osc_tick,
    input wire logic wd_tick,
    // Outputs
    output logic [TRIM_W-1:0] osc_trim_reg,
    output clk_sel_t clock_select_reg,
    output logic [3:0] src_enable,
    output amp_mode_t amp_mode,
    output logic setting_refused,
    output logic sys_clk_release
);

    // ------------------------------------------------------------
    // Tick synchronisers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_OSC = 2'b01,
        ST_WD = 2'b11,
        ST_RUN = 2'b10
    } seq_state_t;

    logic [2:0] osc_sync_r;
    logic [2:0] wd_sync_r;
    logic [2:0] wake_sync_r;
    logic osc_prev_r;
    logic wd_prev_r;
    logic wake_prev_r;
    logic osc_lvl_r;
    logic wd_lvl_r;
    logic wake_lvl_r;

    // Level counts once stages two and three agree
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_sync_r <= 3'h0;
            wd_sync_r <= 3'h0;
            wake_sync_r <= 3'h0;
            osc_lvl_r <= 1'b0;
            wd_lvl_r <= 1'b0;
            wake_lvl_r <= 1'b0;
            osc_prev_r <= 1'b0;
            wd_prev_r <= 1'b0;
            wake_prev_r <= 1'b0;
        end else begin
            osc_sync_r <= {osc_sync_r[1:0], osc_tick};
            wd_sync_r <= {wd_sync_r[1:0], wd_tick};
            wake_sync_r <= {wake_sync_r[1:0], wake_req};
            if (osc_sync_r[1] == osc_sync_r[2]) osc_lvl_r <= osc_sync_r[2];
            if (wd_sync_r[1] == wd_sync_r[2]) wd_lvl_r <= wd_sync_r[2];
            if (wake_sync_r[1] == wake_sync_r[2]) wake_lvl_r <= wake_sync_r[2];
            osc_prev_r <= osc_lvl_r;
            wd_prev_r <= wd_lvl_r;
            wake_prev_r <= wake_lvl_r;
        end
    end

    wire osc_edge = osc_lvl_r & ~osc_prev_r;
    wire wd_edge = wd_lvl_r & ~wd_prev_r;
    wire wake_edge = wake_lvl_r & ~wake_prev_r;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic from_reset_r;
    logic [14:0] osc_cnt_r;
    logic [13:0] wd_cnt_r;
    logic trim_loaded_r;
    startup_plan_t plan_cur;
    startup_plan_t plan_wr;
    startup_plan_t plan_fuse;

    // Trim: factory value after reset, software may override
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_trim_reg <= '0;
            trim_loaded_r <= 1'b0;
        end else if (!trim_loaded_r) begin
            osc_trim_reg <= factory_trim;
            trim_loaded_r <= 1'b1;
        end else if (trim_wr) begin
            osc_trim_reg <= trim_wdata;
        end
    end

    // Fuse copy in the first cycle after reset, then software owns it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clock_select_reg <= '{src_select_field: SRC_FACTORY_DEFAULT, startup_field: SUT_FACTORY_DEFAULT};
        end else if (state_r == ST_LOAD) begin
            clock_select_reg <= '{src_select_field: src_select_fuses, startup_field: startup_fuses};
        end else if (sel_wr && !plan_wr.legal) begin
            clock_select_reg <= clock_select_reg;
        end else if (sel_wr) begin
            clock_select_reg <= sel_wdata;
        end
    end

    // ------------------------------------------------------------
    // Start-up table decode
    // ------------------------------------------------------------
    function automatic startup_plan_t decode(input clk_sel_t s, input logic rst_dis);
        startup_plan_t p;
        logic [2:0] key;
        p = '{osc_clocks: CK_6, wd_cycles: WD_NONE, legal: 1'b1};
        key = {s.src_select_field[0], s.startup_field};
        if (s.src_select_field == SRC_RC_8M || s.src_select_field == SRC_WDOG_128K) begin
            unique case (s.startup_field)
                SUT_00: p.legal = !rst_dis;
                SUT_01: p.wd_cycles = WD_4MS1_CYC;
                SUT_10: p.wd_cycles = WD_65MS_CYC;
                SUT_11: p.legal = 1'b0;
            endcase
        end else if (s.src_select_field[3:1] >= XTAL_MODE_MIN) begin
            unique case (key)
                3'h0: begin p.osc_clocks = CK_258; p.wd_cycles = WD_4MS1_CYC; end
                3'h1: begin p.osc_clocks = CK_258; p.wd_cycles = WD_65MS_CYC; end
                3'h2: begin p.osc_clocks = CK_1K; p.legal = !rst_dis; end
                3'h3: begin p.osc_clocks = CK_1K; p.wd_cycles = WD_4MS1_CYC; end
                3'h4: begin p.osc_clocks = CK_1K; p.wd_cycles = WD_65MS_CYC; end
                3'h5: begin p.osc_clocks = CK_16K; p.legal = !rst_dis; end
                3'h6: begin p.osc_clocks = CK_16K; p.wd_cycles = WD_4MS1_CYC; end
                3'h7: begin p.osc_clocks = CK_16K; p.wd_cycles = WD_65MS_CYC; end
            endcase
        end else begin
            p.legal = 1'b0;
        end
        return p;
    endfunction

    assign plan_cur = decode(clock_select_reg, reset_pin_disable_fuse);
    assign plan_wr = decode(sel_wdata, reset_pin_disable_fuse);
    assign plan_fuse = decode('{src_select_field: src_select_fuses, startup_field: startup_fuses},
        reset_pin_disable_fuse);

    // Source enables and amplifier mode
    assign src_enable = {plan_cur.legal && clock_select_reg.src_select_field[3],
        1'b0,
        clock_select_reg.src_select_field == SRC_WDOG_128K,
        clock_select_reg.src_select_field == SRC_RC_8M};
    assign amp_mode = amp_mode_t'(clock_select_reg.src_select_field[2:1]);

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    wire osc_done = (osc_cnt_r == 15'h0000);
    wire wd_done = (wd_cnt_r == 14'h0000);

    // Hold until oscillator count, then watchdog time-out
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_LOAD: state_nxt = ST_OSC;
            ST_OSC: if (osc_done) state_nxt = (from_reset_r && !wd_done) ? ST_WD : ST_RUN;
            ST_WD: if (wd_done) state_nxt = ST_RUN;
            ST_RUN: if (wake_edge) state_nxt = ST_OSC;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_LOAD;
            from_reset_r <= 1'b1;
            osc_cnt_r <= 15'h0000;
            wd_cnt_r <= 14'h0000;
            setting_refused <= 1'b0;
        end else begin
            state_r <= state_nxt;
            setting_refused <= (state_r == ST_LOAD) ? !plan_fuse.legal : (sel_wr && !plan_wr.legal);
            if (state_r == ST_LOAD) begin
                from_reset_r <= 1'b1;
                osc_cnt_r <= plan_fuse.osc_clocks + (plan_fuse.legal ? CK_RST_14 : 15'h0000);
                wd_cnt_r <= plan_fuse.wd_cycles;
            end else if (state_r == ST_RUN && wake_edge) begin
                from_reset_r <= 1'b0;
                osc_cnt_r <= plan_cur.osc_clocks;
                wd_cnt_r <= WD_NONE;
            end else if (state_r == ST_OSC && !osc_done && osc_edge) begin
                osc_cnt_r <= osc_cnt_r - 15'h0001;
            end else if (state_r == ST_WD && !wd_done && wd_edge) begin
                wd_cnt_r <= wd_cnt_r - 14'h0001;
            end
        end
    end

    assign sys_clk_release = (state_r == ST_RUN);

endmodule

// >>> tb/clock_source_startup_select_sva.sv
/* Checker for the clock start-up block.
 Sees only the top ports; bound after the module. */
`timescale 1ns/1ps
module clk_startup_chk
    import clk_startup_pkg::*;
#(
    parameter int TRIM_W = 8
) (
    // Clock, reset, fuses
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [3:0] src_select_fuses,
    input wire logic [1:0] startup_fuses,
    input wire logic reset_pin_disable_fuse,
    input wire logic [TRIM_W-1:0] factory_trim,
    // Writes and ticks
    input wire logic trim_wr,
    input wire logic [TRIM_W-1:0] trim_wdata,
    input wire logic sel_wr,
    input wire clk_sel_t sel_wdata,
    input wire logic wake_req,
    input wire logic osc_tick,
    input wire logic wd_tick,
    // Outputs
    input wire logic [TRIM_W-1:0] osc_trim_reg,
    input wire clk_sel_t clock_select_reg,
    input wire logic [3:0] src_enable,
    input wire amp_mode_t amp_mode,
    input wire logic setting_refused,
    input wire logic sys_clk_release
);
    logic [1:0] up_r;
    logic [3:0] quiet_r;
    logic ot_r;
    logic wt_r;
    wire logic rc_wr = up_r == 2'h3 && sel_wr && sel_wdata.src_select_field[3:1] == 3'h1;
    // Cycles since reset and since the last tick change
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            up_r <= 2'h0;
            quiet_r <= 4'h0;
            ot_r <= 1'b0;
            wt_r <= 1'b0;
        end else begin
            up_r <= up_r + 2'(up_r != 2'h3);
            quiet_r <= (osc_tick != ot_r || wd_tick != wt_r) ? 4'h0 : quiet_r + 4'(quiet_r != 4'hF);
            ot_r <= osc_tick;
            wt_r <= wd_tick;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    chk_factory_load: assert property (up_r == 2'h1 |-> osc_trim_reg == factory_trim)
        else $error("trim not loaded");
    chk_fuse_copy: assert property (up_r == 2'h1 |-> clock_select_reg == {src_select_fuses, startup_fuses})
        else $error("fuses not copied");
    chk_trim_write: assert property (up_r == 2'h3 && trim_wr |=> osc_trim_reg == $past(trim_wdata))
        else $error("trim write lost");
    chk_rc_enable: assert property (clock_select_reg.src_select_field == SRC_RC_8M |-> src_enable == 4'h1)
        else $error("rc not enabled");
    chk_wd_enable: assert property (clock_select_reg.src_select_field == SRC_WDOG_128K |-> src_enable == 4'h2)
        else $error("128k not enabled");
    chk_amp_range: assert property (clock_select_reg.src_select_field[3] |->
        amp_mode == (clock_select_reg.src_select_field[2] ?
        (clock_select_reg.src_select_field[1] ? AMP_8P0_16P0 : AMP_3P0_8P0) :
        (clock_select_reg.src_select_field[1] ? AMP_0P9_3P0 : AMP_0P4_0P9)) && src_enable == 4'h8)
        else $error("bad amp mode");
    chk_reserved_refused: assert property (rc_wr && sel_wdata.startup_field == SUT_11 |=>
        setting_refused && $stable(clock_select_reg)) else $error("reserved code taken");
    chk_no_timeout_refused: assert property (rc_wr && sel_wdata.startup_field == SUT_00 &&
        reset_pin_disable_fuse |=> setting_refused) else $error("no time-out taken");
    chk_write_accept: assert property (rc_wr && sel_wdata.startup_field == SUT_01 |=>
        clock_select_reg == $past(sel_wdata) && !setting_refused) else $error("write lost");
    chk_release_cause: assert property ($rose(sys_clk_release) |-> quiet_r < 4'h9)
        else $error("release without tick");
    // Main scenarios
    cover property (setting_refused);
    cover property ($rose(sys_clk_release));
    cover property (sel_wr && sel_wdata.src_select_field[3]);
endmodule

bind clock_source_startup_select clk_startup_chk #(.TRIM_W(TRIM_W)) chk (.clock, .arst_n, .src_select_fuses,
    .startup_fuses, .reset_pin_disable_fuse, .factory_trim, .trim_wr, .trim_wdata, .sel_wr, .sel_wdata,
    .wake_req, .osc_tick, .wd_tick, .osc_trim_reg, .clock_select_reg, .src_enable, .amp_mode,
    .setting_refused, .sys_clk_release);

// >>> tb/osc_model.sv
/* Oscillator model: selected source and watchdog ticks.
 Assumes the block's source enables drive it. */
`timescale 1ns/1ps
module osc_model (
    // Enables
    input wire logic [3:0] src_enable,
    // Ticks
    output logic osc_tick,
    output logic wd_tick
);
    initial osc_tick = 1'b0;
    // Watchdog runs whatever the source, offset so it never moves on a block clock edge
    initial begin
        wd_tick = 1'b0;
        #2;
        forever #52 wd_tick = ~wd_tick;
    end
    // Source stands still when disabled
    always #24 osc_tick = (src_enable != 4'h0) ? ~osc_tick : 1'b0;
endmodule

// >>> tb/clock_source_startup_select_tb.sv
/* Testbench for the clock start-up block.
 Assumes the oscillator model and checker beside it. */
`timescale 1ns/1ps
module clock_source_startup_select_tb;
    import clk_startup_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, reset_pin_disable_fuse = 1'b0;
    logic trim_wr = 1'b0, sel_wr = 1'b0, wake_req = 1'b0;
    logic [3:0] src_select_fuses = SRC_RC_8M;
    logic [1:0] startup_fuses = SUT_00;
    logic [7:0] factory_trim = 8'h3C, trim_wdata = 8'h00, osc_trim_reg;
    clk_sel_t sel_wdata = '0, clock_select_reg;
    wire logic osc_tick, wd_tick;
    logic [3:0] src_enable;
    amp_mode_t amp_mode;
    logic setting_refused, sys_clk_release;
    int fails = 0, comparisons = 0;
    // Short time-outs keep the run brief
    clock_source_startup_select #(.WD_4MS1_CYC(14'h0004), .WD_65MS_CYC(14'h0008)) dut (.clock, .arst_n,
        .src_select_fuses, .startup_fuses, .reset_pin_disable_fuse, .factory_trim, .trim_wr, .trim_wdata,
        .sel_wr, .sel_wdata, .wake_req, .osc_tick, .wd_tick, .osc_trim_reg, .clock_select_reg,
        .src_enable, .amp_mode, .setting_refused, .sys_clk_release);
    osc_model partner (.src_enable, .osc_tick, .wd_tick);
    always #4 clock = ~clock;
    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Counts source ticks until release, watchdog ticks once thr source ticks passed
    task automatic settle(input int thr, output int oc, output int wc);
        logic po, pw;
        int n;
        oc = 0;
        wc = 0;
        po = osc_tick;
        pw = wd_tick;
        for (n = 0; n < 20000 && sys_clk_release !== 1'b1; n++) begin
            @(posedge clock);
            if (osc_tick && !po) oc++;
            if (wd_tick && !pw && oc >= thr) wc++;
            po = osc_tick;
            pw = wd_tick;
        end
    endtask
    task automatic t_reset(input logic [3:0] s, input logic [1:0] u, input int n, we);
        int oc, wc;
        src_select_fuses <= s;
        startup_fuses <= u;
        arst_n <= 1'b0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        settle(n, oc, wc);
        check("rst osc", oc + 1 >= n && (we != 0 || oc <= n + 1), 1);
        check("rst wd", wc + 1 >= we && wc <= we + 1, 1);
        check("trim", osc_trim_reg, factory_trim);
        check("sel", clock_select_reg, {s, u});
    endtask
    task automatic write_sel(input clk_sel_t v, output logic r);
        sel_wdata <= v;
        sel_wr <= 1'b1;
        @(posedge clock);
        sel_wr <= 1'b0;
        #1 r = setting_refused;
        @(posedge clock);
    endtask
    // Back-to-back trim writes, last one wins
    task automatic t_trim();
        trim_wdata <= 8'h5A;
        trim_wr <= 1'b1;
        @(posedge clock);
        trim_wdata <= 8'hA5;
        @(posedge clock);
        trim_wr <= 1'b0;
        #1 check("trim wr", osc_trim_reg, 8'hA5);
        @(posedge clock);
    endtask
    task automatic t_refuse();
        logic r;
        reset_pin_disable_fuse <= 1'b1;
        write_sel({SRC_RC_8M, SUT_11}, r);
        check("resv", {r, clock_select_reg}, {1'b1, 4'hC, SUT_00});
        write_sel({SRC_WDOG_128K, SUT_11}, r);
        check("resv wd", r, 1);
        write_sel({SRC_WDOG_128K, SUT_00}, r);
        check("no tmo", {r, clock_select_reg}, {1'b1, 4'hC, SUT_00});
        reset_pin_disable_fuse <= 1'b0;
        write_sel({SRC_WDOG_128K, SUT_00}, r);
        check("tmo ok", {r, clock_select_reg}, {1'b0, SRC_WDOG_128K, SUT_00});
    endtask
    // Amplifier range per crystal code; unsupported sources are refused
    task automatic t_amp();
        logic r;
        write_sel({4'h8, SUT_01}, r);
        check("amp lo", {r, amp_mode, src_enable}, {1'b0, AMP_0P4_0P9, 4'h8});
        write_sel({4'hB, SUT_01}, r);
        check("amp mid", {r, amp_mode, src_enable}, {1'b0, AMP_0P9_3P0, 4'h8});
        write_sel({4'hE, SUT_11}, r);
        check("amp hi", {r, amp_mode, src_enable}, {1'b0, AMP_8P0_16P0, 4'h8});
        write_sel({4'h4, SUT_01}, r);
        check("no lf", {r, clock_select_reg}, {1'b1, 4'hE, SUT_11});
        write_sel({4'h0, SUT_01}, r);
        check("no ext", {r, clock_select_reg}, {1'b1, 4'hE, SUT_11});
    endtask
    task automatic t_wake(input clk_sel_t v, input int n);
        logic r;
        int oc, wc, k;
        write_sel(v, r);
        check("acc", {r, clock_select_reg}, {1'b0, v});
        check("src en", src_enable, v.src_select_field[3] ? 4'h8 : 4'h1);
        if (v.src_select_field[3]) check("amp", amp_mode, AMP_3P0_8P0);
        wake_req <= 1'b1;
        for (k = 0; k < 10 && sys_clk_release !== 1'b0; k++) @(posedge clock);
        wake_req <= 1'b0;
        settle(0, oc, wc);
        check("wake osc", oc + 1 >= n && oc <= n + 1, 1);
    endtask
    initial begin
        t_reset(SRC_RC_8M, SUT_00, 20, 0);
        t_reset(SRC_FACTORY_DEFAULT, SUT_FACTORY_DEFAULT, 20, 8);
        t_reset(SRC_WDOG_128K, SUT_01, 20, 4);
        t_reset(4'hC, SUT_00, 272, 4);
        t_trim();
        t_refuse();
        t_amp();
        t_wake({4'hC, SUT_00}, 258);
        t_wake({4'hD, SUT_00}, 1024);
        t_wake({SRC_RC_8M, SUT_01}, 6);
        finish_test();
    end
    // Whole run needs about 10k cycles
    initial begin
        #400000;
        fails++;
        finish_test();
    end
endmodule
